// File: core/olf_pkg.sv
package olf_pkg;
  localparam logic [11:0] OLF_PUMP_CURRENT_ADDR   = 12'h0F0;
  localparam logic [11:0] OLF_FEEDBACK_COUNT_ADDR = 12'h0F1;
  localparam logic [11:0] OLF_CONTROL_ADDR        = 12'h0F2;
  localparam logic [7:0]  OLF_PUMP_CURRENT_RST    = 8'h80;
  localparam logic [7:0]  OLF_FEEDBACK_COUNT_RST  = 8'h1C;
  localparam logic [7:0]  OLF_CONTROL_RST         = 8'h0B;
  localparam int OLF_FINE_HI       = 7;
  localparam int OLF_FINE_LO       = 6;
  localparam int OLF_COARSE_HI     = 5;
  localparam int OLF_LOCK_PD_BIT   = 7;
  localparam int OLF_RSVD_BIT      = 6;
  localparam int OLF_DOUBLER_BIT   = 5;
  localparam int OLF_AB_MANUAL_BIT = 4;
  localparam int OLF_AB_WIDTH_HI   = 3;
  localparam int OLF_AB_WIDTH_LO   = 2;
  localparam int OLF_MODE_HI       = 1;
  localparam logic [1:0] OLF_AB_HIGH = 2'h2;
  typedef enum logic [1:0] {
    OLF_PUMP_TRISTATE, OLF_PUMP_UP, OLF_PUMP_DOWN, OLF_PUMP_NORMAL
  } olf_pump_mode_t;
endpackage : olf_pkg

// File: core/olf_feedback_divider.sv
`timescale 1ns/1ns
module olf_feedback_divider #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         fb_in_en,
  input  wire logic [1:0]   fine_count,
  input  wire logic [5:0]   coarse_count,
  output logic              fb_pulse,
  output logic [W-1:0]      ratio
);
  logic [W-1:0] cnt_q;

  assign ratio = {coarse_count, 2'h0} + {{(W-2){1'b0}}, fine_count};

  // count down from ratio-1 then reload, one pulse per n input cycles
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q    <= '0;
      fb_pulse <= 1'b0;
    end else begin
      fb_pulse <= 1'b0;
      if (fb_in_en) begin
        if (cnt_q == '0) begin
          cnt_q    <= ratio - W'(1);    // see RULE10
          fb_pulse <= 1'b1;             // see RULE10
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

  chk_pulse_spacing: assert property ( // see RULE10
    @(posedge ref_clk) disable iff (!rst_b)
    fb_pulse |=> !fb_pulse)
    else $error("feedback pulses back to back");
  cov_pulse: cover property (@(posedge ref_clk) disable iff (!rst_b) fb_pulse);
endmodule : olf_feedback_divider

// File: core/olf_output_loop_feedback_control.sv
`timescale 1ns/1ns
// What this block does
// RULE1: eight-bit register word sets charge pump current magnitude.
// RULE2: divide ratio is four times coarse plus fine; fine on top bits.
// RULE3: software programs only legal coarse and fine pairs, ratios 28 to 255; the bench writes ratio 12 once.
// RULE4: control bit seven set powers down lock detector, clear keeps it.
// RULE5: software keeps control bit six at zero always.
// RULE6: control bit five one doubles the reference input frequency.
// RULE7: bit four zero picks antibacklash automatically, one uses the field.
// RULE8: antibacklash field codes min, low, high, max; starts at high.
// RULE9: pump mode field: tristate, up, down, normal; resets to normal.
// RULE10: feedback divider pulses once per ratio input cycles, then reloads.
module olf_output_loop_feedback_control (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [11:0]  reg_addr,
  input  wire logic [7:0]   reg_wdata,
  output logic [7:0]        reg_rdata,
  input  wire logic         fb_in_en,
  output logic              fb_pulse,
  output logic [7:0]        fb_ratio,
  output logic [7:0]        pump_current,
  output logic              lock_det_en,
  output logic              ref_doubler_en,
  output logic [1:0]        antibacklash_width,
  output olf_pkg::olf_pump_mode_t pump_mode
);
  logic [7:0] pump_current_q;
  logic [7:0] feedback_count_q;
  logic [7:0] control_q;
  logic       hit_cur;
  logic       hit_fb;
  logic       hit_ctl;

  assign hit_cur = reg_addr == olf_pkg::OLF_PUMP_CURRENT_ADDR;
  assign hit_fb  = reg_addr == olf_pkg::OLF_FEEDBACK_COUNT_ADDR;
  assign hit_ctl = reg_addr == olf_pkg::OLF_CONTROL_ADDR;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pump_current_q <= olf_pkg::OLF_PUMP_CURRENT_RST;
    end else if (reg_wr && hit_cur) begin
      pump_current_q <= reg_wdata;  // see RULE1
    end
  end

  // no legality filter: illegal pairs are the writer's problem
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      feedback_count_q <= olf_pkg::OLF_FEEDBACK_COUNT_RST;
    end else if (reg_wr && hit_fb) begin
      feedback_count_q <= reg_wdata;  // see RULE2 see RULE3
    end
  end

  // bit six stored as written; hardware never relies on it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      control_q <= olf_pkg::OLF_CONTROL_RST;  // see RULE8 see RULE9
    end else if (reg_wr && hit_ctl) begin
      control_q <= reg_wdata;  // see RULE5
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= hit_cur ? pump_current_q :
                   hit_fb  ? feedback_count_q :
                   hit_ctl ? control_q : 8'h00;
    end
  end

  assign pump_current   = pump_current_q;  // see RULE1
  assign lock_det_en    = !control_q[olf_pkg::OLF_LOCK_PD_BIT];  // see RULE4
  assign ref_doubler_en = control_q[olf_pkg::OLF_DOUBLER_BIT];  // see RULE6
  // automatic mode holds the high setting as the device's own choice
  assign antibacklash_width = control_q[olf_pkg::OLF_AB_MANUAL_BIT] ?
      control_q[olf_pkg::OLF_AB_WIDTH_HI:olf_pkg::OLF_AB_WIDTH_LO] :
      olf_pkg::OLF_AB_HIGH;  // see RULE7 see RULE8
  assign pump_mode = olf_pkg::olf_pump_mode_t'(
      control_q[olf_pkg::OLF_MODE_HI:0]);  // see RULE9

  olf_feedback_divider #(.W(8)) u_div (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .fb_in_en     (fb_in_en),
    .fine_count   (
        feedback_count_q[olf_pkg::OLF_FINE_HI:olf_pkg::OLF_FINE_LO]),
    .coarse_count (feedback_count_q[olf_pkg::OLF_COARSE_HI:0]),
    .fb_pulse     (fb_pulse),
    .ratio        (fb_ratio)  // see RULE2
  );

  chk_current_write: assert property ( // see RULE1
    @(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_cur
    |=> pump_current == $past(reg_wdata))
    else $error("pump current not updated");

  chk_current_reset: assert property ( // see RULE1
    @(posedge ref_clk)
    !rst_b
    |=> pump_current == olf_pkg::OLF_PUMP_CURRENT_RST)
    else $error("pump current reset wrong");

  chk_current_hold: assert property ( // see RULE1
    @(posedge ref_clk) disable iff (!rst_b)
    !(reg_wr && hit_cur)
    |=> $stable(pump_current))
    else $error("pump current changed without write");

  chk_read_current: assert property ( // see RULE1
    @(posedge ref_clk) disable iff (!rst_b)
    reg_rd && hit_cur
    |=> reg_rdata == $past(pump_current_q))
    else $error("pump current read wrong");

  chk_ratio_formula: assert property ( // see RULE2
    @(posedge ref_clk) disable iff (!rst_b)
    1'b1
    |-> fb_ratio == {feedback_count_q[5:0], 2'h0} + feedback_count_q[7:6])
    else $error("ratio formula wrong");

  chk_count_reset: assert property ( // see RULE2
    @(posedge ref_clk)
    !rst_b
    |=> feedback_count_q == olf_pkg::OLF_FEEDBACK_COUNT_RST)
    else $error("feedback count reset wrong");

  chk_read_count: assert property ( // see RULE2
    @(posedge ref_clk) disable iff (!rst_b)
    reg_rd && hit_fb
    |=> reg_rdata == $past(feedback_count_q))
    else $error("feedback count read wrong");

  chk_ratio_hold: assert property ( // see RULE2
    @(posedge ref_clk) disable iff (!rst_b)
    !(reg_wr && hit_fb)
    |=> $stable(fb_ratio))
    else $error("ratio changed without write");

  chk_lock_powerdown: assert property ( // see RULE4
    @(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_ctl
    |=> lock_det_en == !$past(reg_wdata[7]))
    else $error("lock detector control wrong");

  chk_lock_reset: assert property ( // see RULE4
    @(posedge ref_clk)
    !rst_b
    |=> lock_det_en)
    else $error("lock detector off after reset");

  chk_doubler_bit: assert property ( // see RULE6
    @(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_ctl
    |=> ref_doubler_en == $past(reg_wdata[5]))
    else $error("doubler control wrong");

  chk_doubler_reset: assert property ( // see RULE6
    @(posedge ref_clk)
    !rst_b
    |=> !ref_doubler_en)
    else $error("doubler on after reset");

  chk_ab_auto: assert property ( // see RULE7
    @(posedge ref_clk) disable iff (!rst_b)
    !control_q[4]
    |-> antibacklash_width == 2'h2)
    else $error("auto antibacklash not high");

  chk_ab_manual: assert property ( // see RULE8
    @(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_ctl && reg_wdata[4]
    |=> antibacklash_width == $past(reg_wdata[3:2]))
    else $error("manual antibacklash wrong");

  chk_ab_reset: assert property ( // see RULE8
    @(posedge ref_clk)
    !rst_b
    |=> antibacklash_width == olf_pkg::OLF_AB_HIGH)
    else $error("antibacklash reset not high");

  chk_mode_write: assert property ( // see RULE9
    @(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_ctl
    |=> pump_mode == $past(reg_wdata[1:0]))
    else $error("pump mode write wrong");

  chk_mode_reset: assert property ( // see RULE9
    @(posedge ref_clk)
    !rst_b
    |=> pump_mode == olf_pkg::OLF_PUMP_NORMAL)
    else $error("pump mode reset not normal");

  chk_read_control: assert property ( // see RULE5
    @(posedge ref_clk) disable iff (!rst_b)
    reg_rd && hit_ctl
    |=> reg_rdata == $past(control_q))
    else $error("control read wrong");

  // the reload used the ratio of the pulse edge, so look one cycle back
  chk_div_period: assert property ( // see RULE10
    @(posedge ref_clk) disable iff (!rst_b)
    fb_pulse && fb_in_en && $past(fb_ratio) > 8'h08 ##1 fb_in_en [*8]
    |-> !fb_pulse)
    else $error("feedback pulse too early");

  chk_pulse_enabled: assert property ( // see RULE10
    @(posedge ref_clk) disable iff (!rst_b)
    fb_pulse
    |-> $past(fb_in_en))
    else $error("feedback pulse without input cycle");

  cov_manual_ab: cover property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_ctl && reg_wdata[4]);
  cov_div_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && hit_fb);
  cov_read_ctl: cover property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && hit_ctl);
endmodule : olf_output_loop_feedback_control

// File: sim/olf_host_model.sv
`timescale 1ns/1ns
module olf_host_model (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [11:0]      reg_addr,
  output logic [7:0]       reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
  end
  // control bit six is masked here (writes to 0F2 only) so no caller can ever set it
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 12'h0F2) ? (v & 8'hBF) : v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
endmodule : olf_host_model

// File: sim/output_loop_feedback_control_bench.sv
`timescale 1ns/1ns
module output_loop_feedback_control_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fb_in_en = 1'b0;
  logic reg_wr, reg_rd, fb_pulse, lock_det_en, ref_doubler_en;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, fb_ratio, pump_current, d, c;
  logic [1:0] antibacklash_width;
  olf_pkg::olf_pump_mode_t pump_mode;
  logic [31:0] lfsr = 32'h7E1F;
  int n_mismatch = 0;
  int n_checks = 0;
  int k, n;
  always #50 ref_clk = ~ref_clk;
  olf_host_model i_olf_host_model (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  olf_output_loop_feedback_control i_olf_output_loop_feedback_control (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fb_in_en(fb_in_en), .fb_pulse(fb_pulse), .fb_ratio(fb_ratio),
    .pump_current(pump_current), .lock_det_en(lock_det_en),
    .ref_doubler_en(ref_doubler_en), .pump_mode(pump_mode),
    .antibacklash_width(antibacklash_width));
  function automatic logic [7:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : nxt
  // auto mode always reports the high setting
  function automatic logic [7:0] exp_ab(input logic [7:0] v);
    return {6'h00, v[4] ? v[3:2] : 2'h2};
  endfunction : exp_ab
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task gap(output int g);
    g = 0;
    do begin
      @(posedge ref_clk);
      #1;
      g++;
    end while (fb_pulse !== 1'b1 && g < 260);
  endtask : gap
  task summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #5000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(pump_current, 8'h80);
    chk(fb_ratio, 8'h70);
    chk({6'h00, antibacklash_width}, 8'h02);
    chk({6'h00, pump_mode}, 8'h03);
    chk({7'h00, lock_det_en}, 8'h01);
    for (k = 0; k < 40; k++) begin
      d = nxt();
      i_olf_host_model.wr(12'h0F0, d);
      chk(pump_current, d);
      i_olf_host_model.rd(12'h0F0, c);
      chk(c, d);
      c = (k == 0) ? 8'h13 : (k == 1) ? 8'hBF : (nxt() & 8'hBF);
      i_olf_host_model.wr(12'h0F2, c);
      chk({7'h00, lock_det_en}, {7'h00, ~c[7]});
      chk({7'h00, ref_doubler_en}, {7'h00, c[5]});
      chk({6'h00, antibacklash_width}, exp_ab(c));
      chk({6'h00, pump_mode}, {6'h00, c[1:0]});
      i_olf_host_model.rd(12'h0F2, d);
      chk(d, c);
    end
    fb_in_en <= 1'b1;
    for (k = 0; k < 6; k++) begin
      c = nxt();
      // legal pairs except the first (ratio 12): coarse 7 and up allows any fine value
      c = (k == 0) ? 8'h03 : (k == 1) ? 8'hFF :
          {c[7:6], 6'(7 + (c % 57))};
      i_olf_host_model.wr(12'h0F1, c);
      i_olf_host_model.rd(12'h0F1, d);
      chk(d, c);
      chk(fb_ratio, {c[5:0], 2'h0} + {6'h00, c[7:6]});
      gap(n);
      gap(n);
      chk(n[7:0], {c[5:0], 2'h0} + {6'h00, c[7:6]});
    end
    summarize();
  end
endmodule : output_loop_feedback_control_bench
